// ### src/csl_consts.vh
`ifndef CSL_CONSTS_VH
`define CSL_CONSTS_VH

// system clock rate in MHz (period 8 ns)
`define CSL_SYS_CLK_MHZ     125
// half periods of the generated clocks, in system clock cycles
`define CSL_PROC_HALF       2
`define CSL_BUS_HALF        4
`define CSL_REF_HALF        3
// number of processor, stoppable bus and dual-function outputs
`define CSL_PROC_NUM        4
`define CSL_BUS_NUM         5
`define CSL_DUAL_NUM        5
// settle time before strap capture, stands in for the supply threshold
`define CSL_STRAP_SETTLE    8'h10
// power-up timer, in microseconds, and its cycle count (longest time: floor)
`define CSL_PWRUP_TIME_US   3000
`define CSL_PWRUP_CYC       (`CSL_PWRUP_TIME_US * `CSL_SYS_CLK_MHZ)
`define CSL_PWRUP_CW        20
// sequencer states
`define CSL_ST_SAMPLE       2'h0
`define CSL_ST_HOLD         2'h1
`define CSL_ST_RUN          2'h2

`endif

// ### src/csl_clkgate.v
`timescale 1ns/10ps
`include "csl_consts.vh"

module csl_clkgate #(
  parameter HALF  = 2,
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             i_clk,
  input  wire             i_rstn,
  // run request, low parks the outputs low
  input  wire             i_run,
  // gated clock outputs
  output reg [WIDTH-1:0]  o_clk
);

  localparam [7:0] LAST = HALF - 1;

  reg [7:0] cnt_ff;
  reg       ph_ff;

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_ff <= 8'h00;
      ph_ff  <= 1'b0;
      o_clk  <= {WIDTH{1'b0}};
    end else begin
      if (cnt_ff == LAST) begin
        cnt_ff <= 8'h00;
        ph_ff  <= ~ph_ff;
        // a high phase starts only when running: whole pulses, parked low
        if (!ph_ff) begin
          o_clk <= {WIDTH{i_run}};
        end else begin
          o_clk <= {WIDTH{1'b0}};
        end
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

endmodule // csl_clkgate

// ### src/csl_top.v
`timescale 1ns/10ps
`include "csl_consts.vh"

module csl_top #(
  parameter PROC_HALF = `CSL_PROC_HALF,
  parameter BUS_HALF  = `CSL_BUS_HALF,
  parameter REF_HALF  = `CSL_REF_HALF,
  parameter PWRUP_CYC = `CSL_PWRUP_CYC
) (
  // clock and reset
  input  wire                      I_CLK_SYS,
  input  wire                      I_RSTN,
  // halt requests from the chipset
  input  wire                      I_PROC_HALT_N,
  input  wire                      I_BUS_HALT_N,
  // dual-function pins
  input  wire [`CSL_DUAL_NUM-1:0]  I_DUAL_IN,
  output reg  [`CSL_DUAL_NUM-1:0]  O_DUAL_OUT,
  output reg  [`CSL_DUAL_NUM-1:0]  O_DUAL_OE_N,
  // clock outputs
  output wire [`CSL_PROC_NUM-1:0]  O_PROC_CLK,
  output wire                      O_FREE_RUNNING_BUS_CLOCK,
  output wire [`CSL_BUS_NUM-1:0]   O_STOPPABLE_BUS_CLOCKS,
  output wire                      O_REF_CLK,
  // latched strap selection
  output reg  [`CSL_DUAL_NUM-1:0]  O_STRAP_SEL,
  output reg                       O_STRAP_DONE
);

  localparam [`CSL_PWRUP_CW-1:0] PWRUP_LAST = PWRUP_CYC - 1;

  // halt synchronisers, two stages each
  reg        proc_halt_s1_ff;
  reg        proc_halt_s2_ff;
  reg        bus_halt_s1_ff;
  reg        bus_halt_s2_ff;
  // strap synchronisers
  reg [`CSL_DUAL_NUM-1:0] dual_s1_ff;
  reg [`CSL_DUAL_NUM-1:0] dual_s2_ff;
  // sequencer
  reg [1:0]               state_ff;
  reg [1:0]               nxt_state;
  reg [7:0]               settle_ff;
  reg [`CSL_PWRUP_CW-1:0] timer_ff;

  wire free_clk;
  wire ref_clk;

  always @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      proc_halt_s1_ff <= 1'b1;
      proc_halt_s2_ff <= 1'b1;
      bus_halt_s1_ff  <= 1'b1;
      bus_halt_s2_ff  <= 1'b1;
      dual_s1_ff      <= {`CSL_DUAL_NUM{1'b1}};
      dual_s2_ff      <= {`CSL_DUAL_NUM{1'b1}};
    end else begin
      // halt levels change in step with the free bus clock, so two stages suffice
      proc_halt_s1_ff <= I_PROC_HALT_N;
      proc_halt_s2_ff <= proc_halt_s1_ff;
      bus_halt_s1_ff  <= I_BUS_HALT_N;
      bus_halt_s2_ff  <= bus_halt_s1_ff;
      dual_s1_ff      <= I_DUAL_IN;
      dual_s2_ff      <= dual_s1_ff;
    end
  end

  // processor group: gate acts only where a high phase would begin
  csl_clkgate #(
    .HALF  (PROC_HALF),
    .WIDTH (`CSL_PROC_NUM)
  ) u_proc (
    .i_clk  (I_CLK_SYS),
    .i_rstn (I_RSTN),
    .i_run  (proc_halt_s2_ff),
    .o_clk  (O_PROC_CLK)
  );

  // free-running bus clock never gated
  csl_clkgate #(
    .HALF  (BUS_HALF),
    .WIDTH (1)
  ) u_bus_free (
    .i_clk  (I_CLK_SYS),
    .i_rstn (I_RSTN),
    .i_run  (1'b1),
    .o_clk  (free_clk)
  );

  // stoppable bus clocks share phase with the free one
  csl_clkgate #(
    .HALF  (BUS_HALF),
    .WIDTH (`CSL_BUS_NUM)
  ) u_bus_stop (
    .i_clk  (I_CLK_SYS),
    .i_rstn (I_RSTN),
    .i_run  (bus_halt_s2_ff),
    .o_clk  (O_STOPPABLE_BUS_CLOCKS)
  );

  // fixed reference clock keeps running through either halt
  csl_clkgate #(
    .HALF  (REF_HALF),
    .WIDTH (1)
  ) u_ref (
    .i_clk  (I_CLK_SYS),
    .i_rstn (I_RSTN),
    .i_run  (1'b1),
    .o_clk  (ref_clk)
  );

  assign O_FREE_RUNNING_BUS_CLOCK = free_clk;
  assign O_REF_CLK                = ref_clk;

  // power-up sequencer
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `CSL_ST_SAMPLE: begin
        if (settle_ff == `CSL_STRAP_SETTLE) begin
          nxt_state = `CSL_ST_HOLD;
        end
      end
      `CSL_ST_HOLD: begin
        if (timer_ff == PWRUP_LAST) begin
          nxt_state = `CSL_ST_RUN;
        end
      end
      `CSL_ST_RUN: begin
        nxt_state = `CSL_ST_RUN;
      end
      default: begin
        nxt_state = `CSL_ST_SAMPLE;
      end
    endcase
  end

  always @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      state_ff     <= `CSL_ST_SAMPLE;
      settle_ff    <= 8'h00;
      timer_ff     <= {`CSL_PWRUP_CW{1'b0}};
      O_STRAP_SEL  <= {`CSL_DUAL_NUM{1'b1}};
      O_STRAP_DONE <= 1'b0;
      O_DUAL_OUT   <= {`CSL_DUAL_NUM{1'b0}};
      O_DUAL_OE_N  <= {`CSL_DUAL_NUM{1'b1}};
    end else begin
      state_ff <= nxt_state;
      case (state_ff)
        `CSL_ST_SAMPLE: begin
          // pins released as inputs while levels settle
          O_DUAL_OE_N <= {`CSL_DUAL_NUM{1'b1}};
          O_DUAL_OUT  <= {`CSL_DUAL_NUM{1'b0}};
          settle_ff   <= settle_ff + 8'h01;
          if (settle_ff == `CSL_STRAP_SETTLE) begin
            // undriven pin resolves high via pull-up, latched as one
            O_STRAP_SEL  <= dual_s2_ff;
            O_STRAP_DONE <= 1'b1;
            // turn into outputs driven low
            O_DUAL_OE_N  <= {`CSL_DUAL_NUM{1'b0}};
          end
        end
        `CSL_ST_HOLD: begin
          // held low until the power-up timer runs out
          O_DUAL_OUT <= {`CSL_DUAL_NUM{1'b0}};
          timer_ff   <= timer_ff + {{(`CSL_PWRUP_CW-1){1'b0}}, 1'b1};
        end
        `CSL_ST_RUN: begin
          // strap one picks the reference rate, zero the bus rate
          O_DUAL_OUT <= (O_STRAP_SEL & {`CSL_DUAL_NUM{ref_clk}})
                      | (~O_STRAP_SEL & {`CSL_DUAL_NUM{free_clk}});
        end
        default: begin
          O_DUAL_OUT <= {`CSL_DUAL_NUM{1'b0}};
        end
      endcase
      // no path back to sampling, selection never recaptured
    end
  end

endmodule // csl_top

// ### sim/csl_asserts.sv
`timescale 1ns/10ps
module csl_asserts #(
  parameter int BUS_HALF = 4
) (
  // clock, reset and halt inputs
  input logic       I_CLK_SYS, I_RSTN, I_PROC_HALT_N, I_BUS_HALT_N,
  // watched outputs
  input logic [4:0] O_DUAL_OUT, O_DUAL_OE_N, O_STOPPABLE_BUS_CLOCKS, O_STRAP_SEL,
  input logic [3:0] O_PROC_CLK,
  input logic       O_FREE_RUNNING_BUS_CLOCK, O_REF_CLK, O_STRAP_DONE
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  a_proc_park: assert property ((!I_PROC_HALT_N)[*7] |-> O_PROC_CLK == 4'h0)
    else $error("proc clocks not parked");
  a_proc_restart: assert property ($rose(I_PROC_HALT_N) |-> ##[1:8] $rose(O_PROC_CLK[0]))
    else $error("proc restart late");
  a_proc_full: assert property ($rose(O_PROC_CLK[0]) |=> O_PROC_CLK[0] ##1 !O_PROC_CLK[0])
    else $error("proc pulse width");
  a_bus_park: assert property ((!I_BUS_HALT_N)[*8] |-> O_STOPPABLE_BUS_CLOCKS == 5'h00)
    else $error("bus clocks not parked");
  a_bus_restart: assert property ($rose(I_BUS_HALT_N) |-> ##[1:9] $rose(O_STOPPABLE_BUS_CLOCKS[0]))
    else $error("bus restart late");
  a_bus_aligned: assert property ($rose(O_STOPPABLE_BUS_CLOCKS[0]) |->
    $rose(O_FREE_RUNNING_BUS_CLOCK) && O_STOPPABLE_BUS_CLOCKS == 5'h1f)
    else $error("bus restart misaligned");
  a_bus_full: assert property ($rose(O_STOPPABLE_BUS_CLOCKS[0]) |=> O_STOPPABLE_BUS_CLOCKS[0][*3])
    else $error("bus pulse width");
  a_free_toggles: assert property ($rose(O_FREE_RUNNING_BUS_CLOCK) |->
    ##BUS_HALF $fell(O_FREE_RUNNING_BUS_CLOCK))
    else $error("free bus clock stalled");
  a_ref_toggles: assert property ($rose(O_REF_CLK) |-> ##3 $fell(O_REF_CLK))
    else $error("ref clock stalled");
  a_pins_input: assert property (!O_STRAP_DONE |-> O_DUAL_OE_N == 5'h1f)
    else $error("pins driven early");
  a_pins_low: assert property ($rose(O_STRAP_DONE) |-> O_DUAL_OE_N == 5'h00 && O_DUAL_OUT == 5'h00)
    else $error("pins not driven low");
  a_strap_kept: assert property (O_STRAP_DONE |=> O_STRAP_DONE && $stable(O_STRAP_SEL))
    else $error("strap changed");
endmodule // csl_asserts

// ### sim/csl_chipset.sv
`timescale 1ns/10ps
module csl_chipset (
  // clocks
  input  logic i_clk,
  input  logic i_free,
  // requests from the bench
  input  logic i_proc_req,
  input  logic i_bus_req,
  // halts to the device
  output logic o_proc_halt_n = 1'b1,
  output logic o_bus_halt_n  = 1'b1
);
  // halts move only just after a free bus clock rise
  always @(posedge i_free) begin
    @(negedge i_clk);
    o_proc_halt_n <= ~i_proc_req;
    o_bus_halt_n  <= ~i_bus_req;
  end
endmodule // csl_chipset

// ### sim/csl_top_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module csl_top_tb;
  logic       clk = 0, rstn = 0, p_req = 0, b_req = 0, ph_n, bh_n, free, rclk, done;
  logic       ovr = 0;
  logic [4:0] pd = 5'h0a, dout, oe_n, stc, sel, din;
  logic [3:0] pc;
  int         err_count = 0, samples_checked = 0, rc[6];
  initial forever #4 clk = ~clk;
  // pulled-up pins, bench pull-downs where pd is set
  // ovr forces the bench pin levels onto the input even while the device drives
  assign din = ovr ? ~pd : ((~oe_n & dout) | (oe_n & ~pd));
  csl_top #(.PWRUP_CYC(50)) dut_u (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_PROC_HALT_N(ph_n),
    .I_BUS_HALT_N(bh_n), .I_DUAL_IN(din), .O_DUAL_OUT(dout), .O_DUAL_OE_N(oe_n),
    .O_PROC_CLK(pc), .O_FREE_RUNNING_BUS_CLOCK(free), .O_STOPPABLE_BUS_CLOCKS(stc),
    .O_REF_CLK(rclk), .O_STRAP_SEL(sel), .O_STRAP_DONE(done));
  csl_chipset cs_u (.i_clk(clk), .i_free(free), .i_proc_req(p_req), .i_bus_req(b_req),
    .o_proc_halt_n(ph_n), .o_bus_halt_n(bh_n));
  // rising edges over n cycles: proc, free, bus, ref, pin1, pin0
  task automatic cnt(int n);
    logic [5:0] v, w;
    rc = '{default: 0};
    v = {pc[0], free, stc[0], rclk, dout[1:0]};
    repeat (n) begin
      @(negedge clk);
      w = {pc[0], free, stc[0], rclk, dout[1:0]};
      foreach (rc[i]) rc[i] += (w[i] & ~v[i]);
      v = w;
    end
  endtask
  task t_strap;
    int n;
    n = 0;
    `CHK("pin dir", 5'h1f, oe_n)
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK("strap sel", 5'h15, sel)
    `CHK("pin out", 5'h00, oe_n)
    pd = 5'h1f;
    ovr = 1;
    cnt(50);
    `CHK("pin low", 0, rc[0] + rc[1])
    cnt(8);
    cnt(24);
    `CHK("pin ref", 4, rc[0])
    `CHK("pin bus", 3, rc[1])
    `CHK("strap kept", 5'h15, sel)
    ovr = 0;
    $display("test strap done");
  endtask
  task t_halt(logic p, logic b);
    p_req = p;
    b_req = b;
    cnt(24);
    cnt(16);
    `CHK("proc", p ? 0 : 4, rc[5])
    `CHK("free", 2, rc[4])
    `CHK("bus", b ? 0 : 2, rc[3])
    `CHK("ref", 1, rc[2] > 1)
    p_req = 0;
    b_req = 0;
    cnt(16);
    cnt(16);
    `CHK("restart", 6, rc[5] + rc[3])
    $display("test halt %0d%0d done", p, b);
  endtask
  task results;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1;
    t_strap;
    t_halt(1, 0);
    t_halt(0, 1);
    t_halt(1, 1);
    results;
  end
  initial begin
    #16000;
    err_count++;
    results;
  end
endmodule // csl_top_tb
bind csl_top csl_asserts #(.BUS_HALF(BUS_HALF)) chk_u (.I_CLK_SYS, .I_RSTN, .I_PROC_HALT_N,
  .I_BUS_HALT_N, .O_DUAL_OUT, .O_DUAL_OE_N, .O_STOPPABLE_BUS_CLOCKS, .O_STRAP_SEL, .O_PROC_CLK,
  .O_FREE_RUNNING_BUS_CLOCK, .O_REF_CLK, .O_STRAP_DONE);
